/* File: dv/tb_top.sv */
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdl_pkg::*;
  // ============================================================
  // Signals
  // ============================================================
  localparam int unsigned MSC = 4;
  localparam int STD_T [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
  // Rows: write data, expected primary, expected yellow
  localparam logic [21:0] ROWS [7] = '{
    {16'hFFFF, 3'h0, 3'h0}, {16'h7F7F, 3'h1, 3'h0}, {16'hFF7F, 3'h0, 3'h1},
    {16'h1F1F, 3'h7, 3'h0}, {16'hE01F, 3'h0, 3'h7}, {16'hBFDF, 3'h2, 3'h4},
    {16'hC0A0, 3'h4, 3'h2}};
  logic        clk_i, reset_i, io_rd_i, io_wr_i, io_ack_o, mem_rd_i, mem_hit_o;
  logic        wd_alarm_o, wd_running_o, red_alarm_indicator_o, mem_rvalid_o, nv_rd_o;
  logic [15:0] io_addr_i, io_wdata_i, io_rdata_o, rd;
  logic [2:0]  led_primary_o, led_yellow_o;
  logic [1:0]  batt_level_i;
  logic [31:0] nv_base_i, mem_addr_i;
  logic [7:0]  mem_rdata_o, nv_rdata_i;
  logic [18:0] nv_addr_o;
  int          n_errors, check_count, cyc, n;

  // Data line changes with the address so a stale sample is caught
  assign nv_rdata_i = nv_addr_o[7:0] ^ 8'h5A;

  wdl_top #(.MS_CYCLES_P(MSC)) wdl_top_inst (
    .clk_i, .reset_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o,
    .io_ack_o, .wd_alarm_o, .wd_running_o, .red_alarm_indicator_o, .led_primary_o,
    .led_yellow_o, .batt_level_i, .nv_base_i, .mem_rd_i, .mem_addr_i, .mem_hit_o,
    .mem_rvalid_o, .mem_rdata_o, .nv_rd_o, .nv_addr_o, .nv_rdata_i);

  // ============================================================
  // Tasks
  // ============================================================
  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = wr;
    io_rd_i = !wr;
    @(posedge clk_i);
    #1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    chk("ack", 1, io_ack_o);
    rd = io_rdata_o;
  endtask

  // Expiry lags the write by a couple of cycles of pipeline
  task automatic wait_alarm(input int lo);
    n = 0;
    while (wd_alarm_o !== 1'b1 && n < lo + 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("timeout", 1, n >= lo && n <= lo + 3);
  endtask

  task automatic stop_ack();
    io(1'b1, CTRL_ADDR, 16'h0004);
    chk("sticky", 1, wd_alarm_o);
    io(1'b0, CTRL_ADDR, 16'h0000);
    chk("bit7", 1, rd[7]);
    io(1'b1, CTRL_ADDR, 16'h0084);
    @(posedge clk_i);
    #1;
    chk("ack clr", 0, wd_alarm_o);
  endtask

  task automatic mrd(input logic [31:0] a, input logic hit);
    @(posedge clk_i);
    #1;
    mem_addr_i = a;
    mem_rd_i = 1'b1;
    #1;
    chk("hit", hit, mem_hit_o);
    @(posedge clk_i);
    #1;
    mem_rd_i = 1'b0;
    chk("nv_rd", hit, nv_rd_o);
    if (hit) chk("nv_addr", a - nv_base_i, nv_addr_o);
    @(posedge clk_i);
    #1;
    chk("rvalid", hit, mem_rvalid_o);
    if (hit) chk("mdata", (a[7:0] - nv_base_i[7:0]) ^ 8'h5A, mem_rdata_o);
  endtask

  // ============================================================
  // Clock, watchdog on the run, main sequence
  // ============================================================
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 70000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    {io_rd_i, io_wr_i, mem_rd_i} = 3'h0;
    io_addr_i = 16'h0000;
    io_wdata_i = 16'h0000;
    batt_level_i = 2'h0;
    nv_base_i = 32'h0010_0000;
    mem_addr_i = 32'h0000_0000;
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk("rst out", 0, {red_alarm_indicator_o, wd_alarm_o, led_primary_o, led_yellow_o});
    io(1'b0, CTRL_ADDR, 16'h0000);
    chk("rst ctrl", 16'h0000, rd);
    io(1'b0, LED_ADDR, 16'h0000);
    chk("rst led", 16'hFFFF, rd);
    for (int i = 0; i < 7; i++) begin
      io(1'b1, LED_ADDR, ROWS[i][21:6]);
      io(1'b0, LED_ADDR, 16'h0000);
      chk("led rd", ROWS[i][21:6], rd);
      chk("prim", ROWS[i][5:3], led_primary_o);
      chk("yel", ROWS[i][2:0], led_yellow_o);
    end
    io(1'b1, CTRL_ADDR, 16'h0044);
    chk("red on", 1, red_alarm_indicator_o);
    io(1'b0, CTRL_ADDR, 16'h0000);
    chk("ctrl rd", 16'h0044, rd);
    io(1'b1, CTRL_ADDR, 16'h0004);
    chk("red off", 0, red_alarm_indicator_o);
    for (int b = 0; b < 4; b++) begin
      // Monitoring is taken as switched on outside the block
      batt_level_i = b[1:0];
      io(1'b0, BATT_ADDR, 16'h0000);
      chk("batt", {8'h00, b[1:0]}, {rd[15:8], rd[7:6]});
    end
    io(1'b0, 16'h1234, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    repeat (500) @(posedge clk_i);
    #1;
    chk("off", 0, {wd_alarm_o, wd_running_o});
    for (int c = 0; c < 8; c++) begin
      io(1'b1, CTRL_ADDR, {10'h0, c[2:0], 3'b101});
      wait_alarm(STD_T[c] * MSC);
      stop_ack();
    end
    io(1'b1, CTRL_ADDR, 16'h0007);
    wait_alarm(2000 * MSC);
    stop_ack();
    io(1'b1, CTRL_ADDR, 16'h000F);
    wait_alarm(4000 * MSC);
    stop_ack();
    io(1'b1, CTRL_ADDR, 16'h0005);
    repeat (4) begin
      repeat (290) @(posedge clk_i);
      io(1'b0, TRIG_ADDR, 16'h0000);
      chk("trig", 0, wd_alarm_o);
    end
    // A write to the trigger port must leave the count alone
    io(1'b1, TRIG_ADDR, 16'hFFFF);
    wait_alarm(94 * MSC - 2);
    stop_ack();
    io(1'b1, CTRL_ADDR, 16'h0005);
    repeat (300) @(posedge clk_i);
    io(1'b1, CTRL_ADDR, 16'h000D);
    wait_alarm(210 * MSC);
    stop_ack();
    mrd(32'h0010_0005, 1'b1);
    mrd(32'h0017_FFFF, 1'b1);
    mrd(32'h0018_0000, 1'b0);
    mrd(32'h000F_FFFF, 1'b0);
    io(1'b1, CTRL_ADDR, 16'h0045);
    @(posedge clk_i);
    #1;
    chk("mid run", 3, {red_alarm_indicator_o, wd_running_o});
    reset_i = 1'b1;
    #1;
    chk("mid rst", 0, {red_alarm_indicator_o, wd_running_o});
    @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    io(1'b0, CTRL_ADDR, 16'h0000);
    chk("mid ctrl", 16'h0000, rd);
    wrap_up();
  end
endmodule

`default_nettype wire

/* File: dv/wdl_props.sv */
`default_nettype none

// ============================================================
// Port checker
// ============================================================
module wdl_props
  import wdl_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = 4
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_rd_i,
  input wire logic        io_wr_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic        io_ack_o,
  input wire logic        wd_alarm_o,
  input wire logic        wd_running_o,
  input wire logic        red_alarm_indicator_o,
  input wire logic [2:0]  led_primary_o,
  input wire logic [2:0]  led_yellow_o,
  input wire logic [1:0]  batt_level_i,
  input wire logic [31:0] nv_base_i,
  input wire logic        mem_rd_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic        mem_hit_o,
  input wire logic        mem_rvalid_o,
  input wire logic [7:0]  mem_rdata_o,
  input wire logic        nv_rd_o,
  input wire logic [18:0] nv_addr_o,
  input wire logic [7:0]  nv_rdata_i
);
  localparam int unsigned MIN_C = 94 * MS_CYCLES_P;
  logic        wr_ctl;
  logic        restart;
  logic        in_win;
  logic [31:0] off;
  logic [31:0] since_q;
  logic [5:0]  ctl_q;
  logic [2:0]  prim_w;
  logic [2:0]  yel_w;
  logic [15:0] w;

  assign w       = io_wdata_i;
  assign wr_ctl  = io_wr_i && io_addr_i == CTRL_ADDR;
  // Only a changed setup or a fresh enable restarts, as the trigger read does
  assign restart = (wr_ctl && (w[5:1] != ctl_q[5:1] || (w[0] && !ctl_q[0]))) ||
                   (io_rd_i && !io_wr_i && io_addr_i == TRIG_ADDR);
  assign off     = mem_addr_i - nv_base_i;
  assign in_win  = mem_addr_i >= nv_base_i && off < NV_WINDOW_BYTES;
  assign prim_w  = ~{w[13], w[14], w[15]};
  assign yel_w   = {w[13] & ~w[5], w[14] & ~w[6], w[15] & ~w[7]};

  // Cycles since the last event that may restart the count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      since_q <= 32'h0;
      ctl_q   <= 6'h00;
    end else begin
      since_q <= restart ? 32'h0 : since_q + 32'h1;
      if (wr_ctl) begin
        ctl_q <= w[5:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_hit_req;
    mem_rd_i && mem_hit_o;
  endsequence
  sequence s_fetch;
    nv_rd_o && nv_addr_o == $past(off[18:0]) ##1 mem_rvalid_o;
  endsequence

  // ============================================================
  // Assertions
  // ============================================================
  AST_RED: assert property (wr_ctl |=> red_alarm_indicator_o == $past(w[6]))
    else $error("red indicator does not follow control bit 6");
  AST_HOLD: assert property (wd_alarm_o && !(wr_ctl && w[7]) |=> wd_alarm_o)
    else $error("alarm flag dropped without acknowledge");
  AST_CLR: assert property (wr_ctl && w[7] && !wd_running_o |-> ##2 !wd_alarm_o)
    else $error("alarm flag not cleared by acknowledge");
  AST_RISE: assert property ($rose(wd_alarm_o) |-> wd_running_o && since_q >= MIN_C)
    else $error("alarm raised too early or while stopped");
  AST_TRIG: assert property (io_rd_i && io_addr_i == TRIG_ADDR |=> io_ack_o)
    else $error("trigger read not answered");
  AST_BATT: assert property (io_rd_i && !io_wr_i && io_addr_i == BATT_ADDR |=> io_ack_o && io_rdata_o[7:6] == $past(batt_level_i) && io_rdata_o[15:8] == 8'h00)
    else $error("battery level read wrong");
  AST_LEDP: assert property (io_wr_i && io_addr_i == LED_ADDR |-> ##2 led_primary_o == $past(prim_w, 2))
    else $error("green or red indicator wrong");
  AST_LEDY: assert property (io_wr_i && io_addr_i == LED_ADDR |-> ##2 led_yellow_o == $past(yel_w, 2))
    else $error("yellow indicator wrong");
  AST_HIT: assert property (mem_hit_o == (mem_rd_i && in_win))
    else $error("window decode wrong");
  AST_FETCH: assert property (s_hit_req |=> s_fetch)
    else $error("window fetch sequence wrong");
  AST_NVDATA: assert property (mem_rvalid_o |-> mem_rdata_o == $past(nv_rdata_i))
    else $error("window data wrong");
endmodule

bind wdl_top wdl_props #(.MS_CYCLES_P(MS_CYCLES_P)) wdl_props_inst (
  .clk_i, .reset_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o,
  .io_ack_o, .wd_alarm_o, .wd_running_o, .red_alarm_indicator_o, .led_primary_o,
  .led_yellow_o, .batt_level_i, .nv_base_i, .mem_rd_i, .mem_addr_i, .mem_hit_o,
  .mem_rvalid_o, .mem_rdata_o, .nv_rd_o, .nv_addr_o, .nv_rdata_i
);

`default_nettype wire

/* File: logic/wdl_indicator.sv */
`default_nettype none

module wdl_indicator (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic hi_bit_i,
  input  wire logic lo_bit_i,
  output logic      primary_o,
  output logic      yellow_o
);
  import wdl_pkg::*;

  // ==========================================================================
  // Colour decode, registered so the lamp drivers see no decode glitches
  // ==========================================================================
  typedef struct packed {
    logic primary;
    logic yellow;
  } wdl_ind_type;

  wdl_ind_type q, d;

  always_comb begin
    d.primary = ~hi_bit_i;
    d.yellow  = hi_bit_i & ~lo_bit_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{primary: 1'b0, yellow: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign primary_o = q.primary;
  assign yellow_o  = q.yellow;

endmodule

`default_nettype wire

/* File: logic/wdl_pkg.sv */
`default_nettype none

package wdl_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned S_MS          = 1000;

  // ==========================================================================
  // I/O addresses
  // ==========================================================================
  localparam int unsigned IO_ADDR_W  = 16;
  localparam int unsigned IO_DATA_W  = 16;
  localparam logic [15:0] CTRL_ADDR  = 16'h0062;
  localparam logic [15:0] TRIG_ADDR  = 16'h0066;
  localparam logic [15:0] BATT_ADDR  = 16'h404D;
  localparam logic [15:0] LED_ADDR   = 16'h404E;

  // ==========================================================================
  // Control and status register fields
  // ==========================================================================
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_LONG_BIT  = 1;
  localparam int unsigned CTRL_SEL_BIT   = 2;
  localparam int unsigned CTRL_CODE_LSB  = 3;
  localparam int unsigned CTRL_CODE_MSB  = 5;
  localparam int unsigned CTRL_RED_BIT   = 6;
  localparam int unsigned CTRL_ALARM_BIT = 7;
  localparam logic [6:0]  CTRL_RESET     = 7'h00;
  localparam logic [7:0]  TRIG_READ_VAL  = 8'h00;

  // ==========================================================================
  // Indicator and battery registers
  // ==========================================================================
  localparam logic [15:0] LED_RESET    = 16'hFFFF;
  localparam int unsigned LED_COUNT    = 3;
  localparam int unsigned LED_HI_TOP   = 15;
  localparam int unsigned LED_LO_TOP   = 7;
  localparam int unsigned BATT_LVL_LSB = 6;

  // ==========================================================================
  // Nonvolatile RAM window
  // ==========================================================================
  localparam int unsigned NV_ADDR_W      = 19;
  localparam logic [31:0] NV_WINDOW_BYTES = 32'h0008_0000;

  // ==========================================================================
  // Timeout tables, milliseconds and seconds per code
  // ==========================================================================
  localparam logic [15:0] STD_MS [8] = '{16'd94, 16'd210, 16'd340, 16'd460,
                                         16'd590, 16'd710, 16'd840, 16'd960};
  localparam logic [15:0] LONG_S [8] = '{16'd2, 16'd4, 16'd6, 16'd8,
                                         16'd16, 16'd32, 16'd48, 16'd64};

  function automatic logic [15:0] timeout_ms(input logic long_i, input logic [2:0] code_i);
    logic [31:0] prod;
    prod = 32'(LONG_S[code_i]) * S_MS;
    timeout_ms = long_i ? prod[15:0] : STD_MS[code_i];
  endfunction

  typedef enum logic [1:0] {
    TM_IDLE = 2'b01,
    TM_RUN  = 2'b10
  } wdl_tstate_type;

endpackage

`default_nettype wire

/* File: logic/wdl_timer.sv */
`default_nettype none

module wdl_timer #(
  parameter int unsigned MS_CYCLES_P = wdl_pkg::MS_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       enable_i,
  input  wire logic       long_i,
  input  wire logic [2:0] code_i,
  input  wire logic       restart_i,
  output logic            running_o,
  output logic            expire_o
);
  import wdl_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    wdl_tstate_type state;
    logic [31:0]    presc;
    logic [15:0]    ticks;
    logic           expire;
  } wdl_timer_type;

  wdl_timer_type q, d;
  logic [15:0]   limit;

  // ==========================================================================
  // Counting
  // ==========================================================================
  always_comb begin
    limit    = timeout_ms(long_i, code_i);
    d        = q;
    d.expire = 1'b0;
    unique case (q.state)
      TM_IDLE: begin
        d.presc = '0;
        d.ticks = '0;
        if (enable_i) begin
          d.state = TM_RUN;
        end
      end
      TM_RUN: begin
        if (!enable_i) begin
          d.state = TM_IDLE;
          d.presc = '0;
          d.ticks = '0;
        end else if (restart_i) begin
          d.presc = '0;
          d.ticks = '0;
        end else if (q.presc == 32'(MS_CYCLES_P - 1)) begin
          d.presc = '0;
          // Restarts after expiry so a missed trigger keeps raising the alarm
          if (q.ticks == limit - 16'h0001) begin
            d.ticks  = '0;
            d.expire = 1'b1;
          end else begin
            d.ticks = q.ticks + 16'h0001;
          end
        end else begin
          d.presc = q.presc + 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{state: TM_IDLE, presc: '0, ticks: '0, expire: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign running_o = (q.state == TM_RUN);
  assign expire_o  = q.expire;

endmodule

`default_nettype wire

/* File: logic/wdl_top.sv */

`default_nettype none

module wdl_top #(
  parameter int unsigned MS_CYCLES_P = wdl_pkg::MS_CYCLES
) (
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  // Host I/O bus
  input  wire logic [wdl_pkg::IO_ADDR_W-1:0]     io_addr_i,
  input  wire logic                              io_rd_i,
  input  wire logic                              io_wr_i,
  input  wire logic [wdl_pkg::IO_DATA_W-1:0]     io_wdata_i,
  output logic      [wdl_pkg::IO_DATA_W-1:0]     io_rdata_o,
  output logic                                   io_ack_o,
  // Watchdog status
  output logic                                   wd_alarm_o,
  output logic                                   wd_running_o,
  output logic                                   red_alarm_indicator_o,
  // User indicators: 0 first, 1 fault, 2 service
  output logic      [wdl_pkg::LED_COUNT-1:0]     led_primary_o,
  output logic      [wdl_pkg::LED_COUNT-1:0]     led_yellow_o,
  // Battery monitor
  input  wire logic [1:0]                        batt_level_i,
  // Memory read window
  input  wire logic [31:0]                       nv_base_i,
  input  wire logic                              mem_rd_i,
  input  wire logic [31:0]                       mem_addr_i,
  output logic                                   mem_hit_o,
  output logic                                   mem_rvalid_o,
  output logic      [7:0]                        mem_rdata_o,
  // Nonvolatile RAM device side
  output logic                                   nv_rd_o,
  output logic      [wdl_pkg::NV_ADDR_W-1:0]     nv_addr_o,
  input  wire logic [7:0]                        nv_rdata_i
);
  import wdl_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [6:0]           ctrl;
    logic                 alarm;
    logic [15:0]          led;
    logic [IO_DATA_W-1:0] rdata;
    logic                 ack;
    logic                 nv_rd;
    logic [NV_ADDR_W-1:0] nv_addr;
    logic                 mem_rvalid;
    logic [7:0]           mem_rdata;
  } wdl_top_type;

  wdl_top_type q, d;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic        wr_ctrl;
  logic        wr_led;
  logic        rd_any;
  logic        rd_trig;
  logic        mode_change;
  logic        enable_rise;
  logic        restart;
  logic        expire;
  logic        running;
  logic [31:0] nv_offset;
  logic        nv_hit;
  logic [7:0]  ctrl_view;
  logic [7:0]  batt_view;

  function automatic logic [IO_DATA_W-1:0] read_mux(input logic [IO_ADDR_W-1:0] addr,
                                                     input logic [7:0]           ctrl_v,
                                                     input logic [7:0]           batt_v,
                                                     input logic [15:0]          led_v);
    read_mux = '0;
    unique case (addr)
      CTRL_ADDR: read_mux = {8'h00, ctrl_v};
      TRIG_ADDR: read_mux = {8'h00, TRIG_READ_VAL};
      BATT_ADDR: read_mux = {8'h00, batt_v};
      LED_ADDR:  read_mux = led_v;
      default:   read_mux = '0;
    endcase
  endfunction

  always_comb begin
    wr_ctrl = io_wr_i && (io_addr_i == CTRL_ADDR);
    wr_led  = io_wr_i && (io_addr_i == LED_ADDR);
    rd_any  = io_rd_i && !io_wr_i;
    rd_trig = rd_any && (io_addr_i == TRIG_ADDR);
    // Only a real change restarts, so rewriting the same setup cannot mask a hang
    mode_change = wr_ctrl &&
                  (io_wdata_i[CTRL_CODE_MSB:CTRL_LONG_BIT] !=
                   q.ctrl[CTRL_CODE_MSB:CTRL_LONG_BIT]);
    enable_rise = wr_ctrl && io_wdata_i[CTRL_EN_BIT] && !q.ctrl[CTRL_EN_BIT];
    restart     = rd_trig || mode_change || enable_rise;
  end

  // ==========================================================================
  // Register views
  // ==========================================================================
  always_comb begin
    ctrl_view = {q.alarm, q.ctrl};
    batt_view = '0;
    batt_view[BATT_LVL_LSB +: 2] = batt_level_i;
  end

  // ==========================================================================
  // Memory window decode
  // ==========================================================================
  always_comb begin
    nv_offset = mem_addr_i - nv_base_i;
    nv_hit    = (mem_addr_i >= nv_base_i) && (nv_offset < NV_WINDOW_BYTES);
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d            = q;
    d.ack        = 1'b0;
    d.nv_rd      = 1'b0;
    d.mem_rvalid = 1'b0;

    // Control register; the trigger port has no write path at all
    if (wr_ctrl) begin
      d.ctrl[CTRL_EN_BIT]                 = io_wdata_i[CTRL_EN_BIT];
      d.ctrl[CTRL_LONG_BIT]               = io_wdata_i[CTRL_LONG_BIT];
      d.ctrl[CTRL_SEL_BIT]                = io_wdata_i[CTRL_SEL_BIT];
      d.ctrl[CTRL_CODE_MSB:CTRL_CODE_LSB] = io_wdata_i[CTRL_CODE_MSB:CTRL_CODE_LSB];
      d.ctrl[CTRL_RED_BIT]                = io_wdata_i[CTRL_RED_BIT];
    end

    // Sticky alarm; a fresh expiry wins over an acknowledge in the same cycle
    if (expire) begin
      d.alarm = 1'b1;
    end else if (wr_ctrl && io_wdata_i[CTRL_ALARM_BIT]) begin
      d.alarm = 1'b0;
    end

    // Indicator register, reserved bits included
    if (wr_led) begin
      d.led = io_wdata_i;
    end

    // Read data for every mapped address, zero elsewhere
    if (rd_any) begin
      d.rdata = read_mux(io_addr_i, ctrl_view, batt_view, q.led);
      d.ack   = 1'b1;
    end
    if (io_wr_i) begin
      d.ack = 1'b1;
    end

    // Window read: address out, then data captured one cycle later
    if (mem_rd_i && nv_hit) begin
      d.nv_rd   = 1'b1;
      d.nv_addr = nv_offset[NV_ADDR_W-1:0];
    end
    if (q.nv_rd) begin
      d.mem_rvalid = 1'b1;
      d.mem_rdata  = nv_rdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{ctrl: CTRL_RESET, alarm: 1'b0, led: LED_RESET, rdata: '0, ack: 1'b0,
             nv_rd: 1'b0, nv_addr: '0, mem_rvalid: 1'b0, mem_rdata: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Timeout counter
  // ==========================================================================
  wdl_timer #(
    .MS_CYCLES_P (MS_CYCLES_P)
  ) u_timer (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .enable_i  (q.ctrl[CTRL_EN_BIT]),
    .long_i    (q.ctrl[CTRL_LONG_BIT]),
    .code_i    (q.ctrl[CTRL_CODE_MSB:CTRL_CODE_LSB]),
    .restart_i (restart),
    .running_o (running),
    .expire_o  (expire)
  );

  // ==========================================================================
  // User indicators
  // ==========================================================================
  for (genvar i = 0; i < LED_COUNT; i++) begin : g_ind
    wdl_indicator u_ind (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .hi_bit_i  (q.led[LED_HI_TOP - i]),
      .lo_bit_i  (q.led[LED_LO_TOP - i]),
      .primary_o (led_primary_o[i]),
      .yellow_o  (led_yellow_o[i])
    );
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign io_rdata_o            = q.rdata;
  assign io_ack_o              = q.ack;
  assign wd_alarm_o            = q.alarm;
  assign wd_running_o          = running;
  assign red_alarm_indicator_o = q.ctrl[CTRL_RED_BIT];
  assign mem_hit_o             = mem_rd_i && nv_hit;
  assign mem_rvalid_o          = q.mem_rvalid;
  assign mem_rdata_o           = q.mem_rdata;
  assign nv_rd_o               = q.nv_rd;
  assign nv_addr_o             = q.nv_addr;

endmodule

`default_nettype wire
